// ---- rtl/tssc_pkg.sv ----
// tssc_pkg: command codes, field positions and reset values for the
// tearing / access-order / scroll-start command interpreter.
// assumes: both ends share one clock and one synchronous reset.
package tssc_pkg;
   localparam logic [7:0] TSSC_CMD_NOP = 8'h00;
   localparam logic [7:0] TSSC_CMD_SW_RESET = 8'h01;
   localparam logic [7:0] TSSC_CMD_SLEEP_IN = 8'h10;
   localparam logic [7:0] TSSC_CMD_SLEEP_OUT = 8'h11;
   localparam logic [7:0] TSSC_CMD_PARTIAL_ON = 8'h12;
   localparam logic [7:0] TSSC_CMD_NORMAL_ON = 8'h13;
   localparam logic [7:0] TSSC_CMD_TEAR_OFF = 8'h34;
   localparam logic [7:0] TSSC_CMD_TEAR_ON = 8'h35;
   localparam logic [7:0] TSSC_CMD_ACCESS_ORDER = 8'h36;
   localparam logic [7:0] TSSC_CMD_SCROLL_START = 8'h37;
   // access order and tear parameter bit positions; order mask and reset values
   localparam int TSSC_BIT_ROW_ORDER = 7;
   localparam int TSSC_BIT_COL_ORDER = 6;
   localparam int TSSC_BIT_ROW_COL_SWAP = 5;
   localparam int TSSC_BIT_SCAN_DIR = 4;
   localparam int TSSC_BIT_BGR = 3;
   localparam logic [7:0] TSSC_ORDER_KEEP_MASK = 8'hF8;
   localparam int TSSC_BIT_TEAR_MODE = 0;
   localparam logic [7:0] TSSC_ORDER_RESET = 8'h00;
   localparam logic [15:0] TSSC_SCROLL_RESET = 16'h0000;
   // host command port (software side)
   localparam logic [1:0] TSSC_ADDR_CMD = 2'h0;
   localparam logic [1:0] TSSC_ADDR_PARAM = 2'h1;
   localparam logic [1:0] TSSC_ADDR_STATUS = 2'h2;
endpackage

// ---- rtl/tssc_link_if.sv ----
// tssc_link_if: byte link from host to display device.
// assumes: one byte per cycle when wr_stb high, no back-pressure.
`timescale 1ns/1ps
interface tssc_link_if;
   logic wr_stb;
   logic data_cmd_sel;
   logic [7:0] data;
   modport host (output wr_stb, output data_cmd_sel, output data);
   modport dev (input wr_stb, input data_cmd_sel, input data);
endinterface

// ---- rtl/tssc_dev.sv ----
// tssc_dev: device end; decodes tearing, access order and scroll start.
// assumes: link bytes arrive synchronous to i_sys_clk; frame and line
// blanking come from the panel timing logic on the same clock.
`timescale 1ns/1ps
module tssc_dev
   import tssc_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // link from host
   tssc_link_if.dev link,
   // panel timing
   input wire logic i_frame_start,
   input wire logic i_vblank,
   input wire logic i_hblank,
   // settings out
   output logic o_tear_sync_out,
   output logic o_row_order,
   output logic o_col_order,
   output logic o_row_col_swap,
   output logic o_refresh_scan_dir,
   output logic o_bgr_order,
   output logic [15:0] o_scroll_start_line,
   output logic o_scroll_mode,
   output logic o_partial_mode,
   output logic o_sleep_mode
);
   typedef enum {TSSC_IDLE, TSSC_TEAR_P, TSSC_ORDER_P, TSSC_SCROLL_HI,
                 TSSC_SCROLL_LO} tssc_dec_e;

   tssc_dec_e state_reg;
   logic tear_en_reg;
   logic tear_mode_reg;
   logic [7:0] order_reg;
   logic [7:0] scroll_hi_reg;
   logic [15:0] scroll_pend_reg;
   logic scroll_upd_reg;
   logic [15:0] scroll_reg;
   logic scroll_mode_reg;
   logic partial_reg;
   logic sleep_reg;
   logic tear_out_reg;
   logic cmd_stb;
   logic par_stb;
   logic sw_rst;
   logic mode_exit;

   // command of the given code taken this cycle
   function automatic logic cmd_is(input logic stb, input logic [7:0] val,
         input logic [7:0] code);
      return stb && val == code;
   endfunction

   // parameter byte taken while the sequencer waits in the given state
   function automatic logic par_in(input logic stb, input tssc_dec_e cur,
         input tssc_dec_e want);
      return stb && cur == want;
   endfunction

   assign cmd_stb = link.wr_stb && !link.data_cmd_sel;
   assign par_stb = link.wr_stb && link.data_cmd_sel;
   assign sw_rst = cmd_is(cmd_stb, link.data, TSSC_CMD_SW_RESET);
   // partial-on and normal-on both leave vertical scroll
   assign mode_exit = cmd_is(cmd_stb, link.data, TSSC_CMD_PARTIAL_ON)
      || cmd_is(cmd_stb, link.data, TSSC_CMD_NORMAL_ON);

   // parameter sequencing; a command byte always restarts it
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_reg <= TSSC_IDLE;
      end else if (cmd_stb) begin
         unique case (link.data)
            TSSC_CMD_TEAR_ON: state_reg <= TSSC_TEAR_P;
            TSSC_CMD_ACCESS_ORDER: state_reg <= TSSC_ORDER_P;
            TSSC_CMD_SCROLL_START: begin
               // partial mode drops the command and its bytes
               state_reg <= partial_reg ? TSSC_IDLE : TSSC_SCROLL_HI;
            end
            default: state_reg <= TSSC_IDLE;
         endcase
      end else if (par_stb) begin
         unique case (state_reg)
            TSSC_SCROLL_HI: state_reg <= TSSC_SCROLL_LO;
            // stray or extra bytes fall back to idle and are dropped
            default: state_reg <= TSSC_IDLE;
         endcase
      end
   end

   // tearing enable and mode
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || sw_rst) begin
         tear_en_reg <= 1'b0;
         tear_mode_reg <= 1'b0;
      end else if (cmd_is(cmd_stb, link.data, TSSC_CMD_TEAR_OFF)) begin
         tear_en_reg <= 1'b0;
      end else if (par_in(par_stb, state_reg, TSSC_TEAR_P)) begin
         // only bit0 matters; the rest of the byte is ignored
         tear_en_reg <= 1'b1;
         tear_mode_reg <= link.data[TSSC_BIT_TEAR_MODE];
      end
   end

   // access order; soft reset leaves it alone
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         order_reg <= TSSC_ORDER_RESET;
      end else if (par_in(par_stb, state_reg, TSSC_ORDER_P)) begin
         order_reg <= link.data & TSSC_ORDER_KEEP_MASK;
      end
   end

   // scroll start line: high byte held, whole word staged on low byte
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || sw_rst) begin
         scroll_hi_reg <= TSSC_SCROLL_RESET[15:8];
         scroll_pend_reg <= TSSC_SCROLL_RESET;
         scroll_upd_reg <= 1'b0;
         scroll_reg <= TSSC_SCROLL_RESET;
      end else begin
         if (par_in(par_stb, state_reg, TSSC_SCROLL_HI)) begin
            scroll_hi_reg <= link.data;
         end
         // a low byte beside a frame start waits for the next frame
         if (par_in(par_stb, state_reg, TSSC_SCROLL_LO)) begin
            scroll_pend_reg <= {scroll_hi_reg, link.data};
            scroll_upd_reg <= 1'b1;
         end else if (i_frame_start && scroll_upd_reg) begin
            scroll_reg <= scroll_pend_reg;
            scroll_upd_reg <= 1'b0;
         end
      end
   end

   // display modes
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || sw_rst) begin
         scroll_mode_reg <= 1'b0;
         partial_reg <= 1'b0;
         sleep_reg <= 1'b1;
      end else begin
         if (mode_exit) begin
            scroll_mode_reg <= 1'b0;
            partial_reg <= cmd_is(cmd_stb, link.data, TSSC_CMD_PARTIAL_ON);
         end else if (par_in(par_stb, state_reg, TSSC_SCROLL_LO)) begin
            scroll_mode_reg <= 1'b1;
         end
         // power-up is sleep-in, so the tear pin stays low until sleep-out
         if (cmd_is(cmd_stb, link.data, TSSC_CMD_SLEEP_IN)) begin
            sleep_reg <= 1'b1;
         end else if (cmd_is(cmd_stb, link.data, TSSC_CMD_SLEEP_OUT)) begin
            sleep_reg <= 1'b0;
         end
      end
   end

   // tear output registered; scan direction deliberately not involved
   // one cycle behind the blanking inputs, so the pin never glitches
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         tear_out_reg <= 1'b0;
      end else if (!tear_en_reg || sleep_reg) begin
         tear_out_reg <= 1'b0;
      end else if (tear_mode_reg) begin
         tear_out_reg <= i_vblank || i_hblank;
      end else begin
         tear_out_reg <= i_vblank;
      end
   end

   assign o_tear_sync_out = tear_out_reg;
   assign o_row_order = order_reg[TSSC_BIT_ROW_ORDER];
   assign o_col_order = order_reg[TSSC_BIT_COL_ORDER];
   assign o_row_col_swap = order_reg[TSSC_BIT_ROW_COL_SWAP];
   assign o_refresh_scan_dir = order_reg[TSSC_BIT_SCAN_DIR];
   assign o_bgr_order = order_reg[TSSC_BIT_BGR];
   // scan address; row mapping is done by the refresh logic
   assign o_scroll_start_line = scroll_reg;
   assign o_scroll_mode = scroll_mode_reg;
   assign o_partial_mode = partial_reg;
   assign o_sleep_mode = sleep_reg;
endmodule

// ---- rtl/tssc_host.sv ----
// tssc_host: host end; software queues command and parameter bytes.
// assumes: software writes one byte per strobe; no waiting on the link.
`timescale 1ns/1ps
module tssc_host
   import tssc_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // software port
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // link to device
   tssc_link_if.host link
);
   logic wr_stb_reg;
   logic dcs_reg;
   logic [7:0] data_reg;
   logic [7:0] last_cmd_reg;
   logic [7:0] rdata_reg;

   // each software write to the command or parameter address becomes one link byte, next cycle
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         wr_stb_reg <= 1'b0;
         dcs_reg <= 1'b0;
         data_reg <= 8'h00;
      end else begin
         wr_stb_reg <= i_wr && (i_addr == TSSC_ADDR_CMD || i_addr == TSSC_ADDR_PARAM);
         if (i_wr) begin
            dcs_reg <= i_addr == TSSC_ADDR_PARAM;
            data_reg <= i_wdata;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         last_cmd_reg <= TSSC_CMD_NOP;
      end else if (i_wr && i_addr == TSSC_ADDR_CMD) begin
         last_cmd_reg <= i_wdata;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rdata_reg <= 8'h00;
      end else if (i_rd && i_addr == TSSC_ADDR_STATUS) begin
         rdata_reg <= last_cmd_reg;
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign link.wr_stb = wr_stb_reg;
   assign link.data_cmd_sel = dcs_reg;
   assign link.data = data_reg;
   assign o_rdata = rdata_reg;
endmodule

// ---- verif/tssc_assertions.sv ----
// tssc_assertions: link and device-output checks for the command interpreter.
// assumes: one clock, sync active-low reset, instantiated beside the link.
`timescale 1ns/1ps
module tssc_assertions
   import tssc_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // link
   input wire logic wr_stb,
   input wire logic data_cmd_sel,
   input wire logic [7:0] data,
   // panel timing
   input wire logic i_frame_start,
   input wire logic i_vblank,
   input wire logic i_hblank,
   // device outputs
   input wire logic o_tear_sync_out,
   input wire logic o_row_order,
   input wire logic o_col_order,
   input wire logic o_row_col_swap,
   input wire logic o_refresh_scan_dir,
   input wire logic o_bgr_order,
   input wire logic [15:0] o_scroll_start_line,
   input wire logic o_scroll_mode,
   input wire logic o_partial_mode,
   input wire logic o_sleep_mode
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] cmd_q;
   logic [1:0] pcnt;
   logic mode_q;
   wire logic cmd = wr_stb && !data_cmd_sel;
   wire logic par = wr_stb && data_cmd_sel;
   wire logic swr = cmd && data == TSSC_CMD_SW_RESET;
   wire logic [4:0] ord = data[7:3];
   // parameter counter saturates so stray bytes never wrap onto a field
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cmd_q <= TSSC_CMD_NOP;
         pcnt <= 2'h0;
      end else if (cmd) begin
         cmd_q <= data;
         pcnt <= 2'h0;
      end else if (par && pcnt != 2'h3) begin
         pcnt <= pcnt + 2'h1;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || swr) begin
         mode_q <= 1'b0;
      end else if (par && cmd_q == TSSC_CMD_TEAR_ON && pcnt == 2'h0) begin
         mode_q <= data[0];
      end
   end
   chk_tear_off_low: assert property (
      cmd && data == TSSC_CMD_TEAR_OFF |-> ##2 !o_tear_sync_out [*2])
      else $error("tear output high after tear off");
   chk_sleep_low: assert property (o_sleep_mode |=> !o_tear_sync_out)
      else $error("tear output high in sleep");
   chk_tear_cause: assert property (o_tear_sync_out |->
      $past(i_vblank) || ($past(mode_q) && $past(i_hblank)))
      else $error("tear output without blanking cause");
   chk_order_bits: assert property (
      par && cmd_q == TSSC_CMD_ACCESS_ORDER && pcnt == 2'h0 |=>
      {o_row_order, o_col_order, o_row_col_swap, o_refresh_scan_dir, o_bgr_order}
      == $past(ord))
      else $error("access order fields wrong");
   chk_scroll_enter: assert property (
      par && cmd_q == TSSC_CMD_SCROLL_START && pcnt == 2'h1 && !o_partial_mode
      |=> o_scroll_mode)
      else $error("scroll mode not entered");
   chk_scroll_exit: assert property (
      cmd && (data == TSSC_CMD_PARTIAL_ON || data == TSSC_CMD_NORMAL_ON) |=> !o_scroll_mode)
      else $error("scroll mode kept after exit command");
   chk_partial_refuse: assert property (o_partial_mode |-> !o_scroll_mode)
      else $error("scroll mode while partial");
   chk_line_at_frame: assert property (
      !$stable(o_scroll_start_line) |-> $past(i_frame_start) || $past(swr))
      else $error("scroll line changed mid scan");
   chk_reset_values: assert property ($rose(i_rst_n) |->
      !o_tear_sync_out && o_sleep_mode && !o_scroll_mode && !o_partial_mode
      && o_scroll_start_line == TSSC_SCROLL_RESET
      && {o_row_order, o_col_order, o_row_col_swap, o_refresh_scan_dir, o_bgr_order}
      == TSSC_ORDER_RESET[7:3])
      else $error("reset values wrong");
   cover property (o_tear_sync_out && mode_q && !i_vblank);
   cover property ($rose(o_scroll_mode));
   cover property (o_partial_mode && cmd && data == TSSC_CMD_SCROLL_START);
endmodule

// ---- verif/tear_scan_scroll_cmds_tb.sv ----
// tear_scan_scroll_cmds_tb: host and device ends joined; software port driven.
// assumes: status read returns the last command byte, zero after reset.
`timescale 1ns/1ps
module tear_scan_scroll_cmds_tb;
   import tssc_pkg::*;
   logic i_sys_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, rd_d = 0;
   logic i_frame_start = 0, i_vblank = 0, i_hblank = 0;
   logic [1:0] i_addr = 0;
   logic [7:0] i_wdata = 0, o_rdata, b, h, lc = 0;
   logic o_tear_sync_out, o_row_order, o_col_order, o_row_col_swap, o_refresh_scan_dir;
   logic o_bgr_order, o_scroll_mode, o_partial_mode, o_sleep_mode;
   logic [15:0] o_scroll_start_line, ln = 0;
   logic [32:0] exp_q[$];
   logic [32:0] seen, want;
   logic en = 0, md = 0, sm = 0, pt = 0, sl = 1;
   logic [4:0] ord = 0;
   int num_errors = 0, check_count = 0, cyc = 0;
   tssc_link_if lnk();
   tssc_host tssc_host_inst (.i_sys_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata, .link(lnk));
   tssc_dev tssc_dev_inst (.i_sys_clk, .i_rst_n, .link(lnk), .i_frame_start, .i_vblank,
      .i_hblank, .o_tear_sync_out, .o_row_order, .o_col_order, .o_row_col_swap,
      .o_refresh_scan_dir, .o_bgr_order, .o_scroll_start_line, .o_scroll_mode,
      .o_partial_mode, .o_sleep_mode);
   tssc_assertions tssc_assertions_inst (.i_sys_clk, .i_rst_n, .wr_stb(lnk.wr_stb),
      .data_cmd_sel(lnk.data_cmd_sel), .data(lnk.data), .i_frame_start, .i_vblank,
      .i_hblank, .o_tear_sync_out, .o_row_order, .o_col_order, .o_row_col_swap,
      .o_refresh_scan_dir, .o_bgr_order, .o_scroll_start_line, .o_scroll_mode,
      .o_partial_mode, .o_sleep_mode);
   initial forever #5 i_sys_clk = ~i_sys_clk;
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic cmd(input logic [7:0] c);
      lc = c;
      wr(TSSC_ADDR_CMD, c);
   endtask
   task automatic fs();
      i_frame_start <= 1'b1;
      @(posedge i_sys_clk);
      i_frame_start <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   // expected tear level is worked out from the held blanking inputs
   task automatic chk();
      repeat (2) @(posedge i_sys_clk);
      exp_q.push_back({lc, en & !sl & (i_vblank | (md & i_hblank)), ord, sm, pt, sl, ln});
      i_addr <= TSSC_ADDR_STATUS;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(posedge i_sys_clk);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge i_sys_clk) begin
      rd_d <= i_rd;
      cyc++;
      if (rd_d) begin
         seen = {o_rdata, o_tear_sync_out, o_row_order, o_col_order, o_row_col_swap,
            o_refresh_scan_dir, o_bgr_order, o_scroll_mode, o_partial_mode, o_sleep_mode,
            o_scroll_start_line};
         want = exp_q.pop_front();
         check_count++;
         if (seen !== want) begin
            num_errors++;
            $display("wrong value settings expected %h seen %h", want, seen);
         end
      end
      if (cyc == 3000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      void'($urandom(10));
      repeat (16) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      i_vblank <= 1'b1;
      @(posedge i_sys_clk);
      chk();
      b = 8'($urandom);
      cmd(8'h35);
      wr(TSSC_ADDR_PARAM, b & 8'hFE);
      en = 1;
      chk();
      cmd(8'h11);
      sl = 0;
      chk();
      i_vblank <= 1'b0;
      i_hblank <= 1'b1;
      chk();
      cmd(8'h35);
      wr(TSSC_ADDR_PARAM, b | 8'h01);
      md = 1;
      chk();
      for (int k = 0; k < 4; k++) begin
         b = 8'($urandom);
         cmd(8'h36);
         wr(TSSC_ADDR_PARAM, b);
         ord = b[7:3];
         chk();
      end
      // no fixed areas are set up, so any start line lies in the scroll area
      h = 8'($urandom);
      b = 8'($urandom);
      cmd(8'h37);
      wr(TSSC_ADDR_PARAM, h);
      wr(TSSC_ADDR_PARAM, b);
      sm = 1;
      chk();
      fs();
      ln = {h, b};
      chk();
      cmd(8'h37);
      wr(TSSC_ADDR_PARAM, ~h);
      fs();
      chk();
      cmd(8'h00);
      wr(TSSC_ADDR_PARAM, ~b);
      fs();
      chk();
      cmd(8'h12);
      pt = 1;
      sm = 0;
      cmd(8'h37);
      wr(TSSC_ADDR_PARAM, ~h);
      wr(TSSC_ADDR_PARAM, ~b);
      fs();
      chk();
      cmd(8'h13);
      pt = 0;
      i_vblank <= 1'b1;
      cmd(8'h10);
      sl = 1;
      chk();
      cmd(8'h11);
      sl = 0;
      cmd(8'h34);
      en = 0;
      // a write to the status address must not reach the link as a soft reset
      wr(TSSC_ADDR_STATUS, 8'h01);
      chk();
      cmd(8'h35);
      wr(TSSC_ADDR_PARAM, 8'h01);
      cmd(8'h01);
      {en, md, sm, pt, sl, ln} = {5'h01, 16'h0000};
      chk();
      // let the monitor take the last compare before the verdict
      @(posedge i_sys_clk);
      close_out();
   end
endmodule
